// ---- hdl/ssi_filter.sv ----
module ssi_filter #(
    parameter longint unsigned DEB_CYCLES = ssi_pkg::DEBOUNCE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic raw,
    output logic filtered
);
    localparam int CW = $clog2(DEB_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(DEB_CYCLES - 1);

    typedef struct packed {
        logic s1;
        logic s2;
        logic stable;
        logic [CW-1:0] cnt;
    } ssi_filter_t;

    ssi_filter_t s;
    ssi_filter_t next_s;

    // the level must hold for the whole window before it is believed
    always_comb begin
        next_s = s;
        next_s.s1 = raw;
        next_s.s2 = s.s1;
        if (s.s2 == s.stable) begin
            next_s.cnt = '0;
        end else if (s.cnt >= LAST) begin
            next_s.stable = s.s2;
            next_s.cnt = '0;
        end else begin
            next_s.cnt = s.cnt + CW'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign filtered = s.stable;

    debounce_window_a: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(s.stable) |-> s.stable == $past(s.s2) && $past(s.cnt) == LAST)
        else $error("filtered level changed before the window ran out");
endmodule

// ---- hdl/ssi_hold_timer.sv ----
module ssi_hold_timer #(
    parameter longint unsigned CYCLES = ssi_pkg::PRESET_HOLD_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic trig,
    output logic active
);
    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
    } ssi_timer_t;

    ssi_timer_t s;
    ssi_timer_t next_s;

    // reloads while triggered, then runs down once the trigger falls
    always_comb begin
        next_s = s;
        if (trig) begin
            next_s.cnt = CW'(CYCLES);
        end else if (s.cnt != '0) begin
            next_s.cnt = s.cnt - CW'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign active = (s.cnt != '0);
endmodule

// ---- hdl/ssi_interlock.sv ----
module ssi_interlock #(
    parameter longint unsigned PRESET_HOLD_CYCLES = ssi_pkg::PRESET_HOLD_CYC,
    parameter longint unsigned DEBOUNCE_CYCLES = ssi_pkg::DEBOUNCE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic preset_push_command,
    input wire logic key_bank_complete,
    input wire logic inner_gate_closed,
    input wire logic outer_door_closed,
    input wire logic reset_button_local,
    input wire logic reset_button_room,
    input wire logic door_switch_ok,
    input wire logic emergency_off_ok,
    input wire logic emergency_entry_ok,
    input wire logic stoppers_inserted,
    input wire logic hazards_off,
    input wire logic hw_enable,
    input wire logic interlock_reset_button,
    output logic stopper_permit,
    output logic hazard_permit,
    output logic modulator_power_source_permit,
    output logic key_release_permit,
    output logic door_latch_permit,
    output logic preset_active,
    output logic search_reset_active,
    output logic irq
);
    typedef struct packed {
        logic preset;
        logic search_reset;
        logic [2:0] ilk;
        logic violation;
        ssi_pkg::ssi_access_t access;
        logic key_req;
        logic door_req;
        logic [ssi_pkg::IRQ_W-1:0] irq_stat;
        logic [ssi_pkg::IRQ_W-1:0] irq_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic stopper_permit;
        logic hazard_permit;
        logic mod_permit;
        logic key_permit;
        logic door_permit;
        logic irq;
    } ssi_state_t;

    ssi_state_t s;
    ssi_state_t next_s;

    logic [ssi_pkg::NUM_IN-1:0] raw;
    logic [ssi_pkg::NUM_IN-1:0] f;
    logic timer_active;

    assign raw = {interlock_reset_button, hw_enable, hazards_off, stoppers_inserted,
                  emergency_entry_ok, emergency_off_ok, door_switch_ok, reset_button_room,
                  reset_button_local, outer_door_closed, inner_gate_closed, key_bank_complete,
                  preset_push_command};

    // every pin passes its own synchroniser and debounce
    genvar gi;
    generate
        for (gi = 0; gi < ssi_pkg::NUM_IN; gi++) begin : g_in
            ssi_filter #(.DEB_CYCLES(DEBOUNCE_CYCLES)) u_filt (
                .ref_clk(ref_clk),
                .rst(rst),
                .raw(raw[gi]),
                .filtered(f[gi])
            );
        end
    endgenerate

    ssi_hold_timer #(.CYCLES(PRESET_HOLD_CYCLES)) u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .trig(!f[ssi_pkg::IN_KEYS_COMPLETE] && !f[ssi_pkg::IN_GATE_CLOSED]),
        .active(timer_active)
    );

    logic [2:0] contacts;
    logic ilk_reset;
    logic quals;
    logic beam_zone;
    logic entry_state;
    logic wr;
    logic rd_setup;
    logic mapped;
    logic [1:0] wr_access;
    logic [ssi_pkg::IRQ_W-1:0] events;

    always_comb begin
        contacts = {f[ssi_pkg::IN_EMERG_OK], f[ssi_pkg::IN_EOFF_OK], f[ssi_pkg::IN_DOOR_SW_OK]};
        beam_zone = (s.access == ssi_pkg::SSI_RESTRICTED) || (s.access == ssi_pkg::SSI_NO_ACCESS);
        entry_state = (s.access == ssi_pkg::SSI_PERMITTED) || (s.access == ssi_pkg::SSI_CONTROLLED);
        wr = psel && penable && s.pready && pwrite;
        rd_setup = psel && !penable;
        mapped = (paddr == ssi_pkg::OFS_CTRL) || (paddr == ssi_pkg::OFS_CMD) || (paddr == ssi_pkg::OFS_STATUS)
                 || (paddr == ssi_pkg::OFS_IRQ_STAT) || (paddr == ssi_pkg::OFS_IRQ_MASK);
        wr_access = pwdata[ssi_pkg::CTRL_ACCESS_LSB +: 2];
        // software reset command only counts with the hardware enable held
        ilk_reset = f[ssi_pkg::IN_ILK_RESET] || (wr && paddr == ssi_pkg::OFS_CMD
                    && pwdata[ssi_pkg::CMD_ILK_RESET_BIT] && f[ssi_pkg::IN_HW_ENABLE]);
        quals = f[ssi_pkg::IN_GATE_CLOSED] && f[ssi_pkg::IN_DOOR_CLOSED]
                && f[ssi_pkg::IN_KEYS_COMPLETE] && (&s.ilk);
        next_s = s;
        events = '0;

        // trip latches: reset only re-arms a contact that is healthy now
        for (int i = 0; i < 3; i++) begin
            next_s.ilk[i] = contacts[i] && (s.ilk[i] || ilk_reset);
        end
        events[ssi_pkg::IRQ_ILK_TRIP] = |(s.ilk & ~contacts);

        // set needs both buttons in the same filtered cycle and a live preset
        next_s.search_reset = quals && (s.search_reset
                              || (s.preset && f[ssi_pkg::IN_RESET_LOCAL] && f[ssi_pkg::IN_RESET_ROOM]));
        events[ssi_pkg::IRQ_SR_SET] = !s.search_reset && next_s.search_reset;
        events[ssi_pkg::IRQ_SR_LOST] = s.search_reset && !next_s.search_reset;

        // a lost search reset drops preset too, so the whole sequence must repeat
        next_s.preset = (f[ssi_pkg::IN_PRESET] || (s.preset && (timer_active || s.search_reset)))
                        && !events[ssi_pkg::IRQ_SR_LOST];
        events[ssi_pkg::IRQ_PRESET_SET] = !s.preset && next_s.preset;

        // only a loss in a zone that may see beam is a violation
        if (events[ssi_pkg::IRQ_SR_LOST] && beam_zone) begin
            next_s.violation = 1'h1;
        end else if (ilk_reset) begin
            next_s.violation = 1'h0;
        end
        events[ssi_pkg::IRQ_VIOLATION] = !s.violation && next_s.violation;

        next_s.stopper_permit = next_s.search_reset && beam_zone && !next_s.violation;
        next_s.hazard_permit = next_s.search_reset && beam_zone && !next_s.violation;
        next_s.mod_permit = !next_s.violation;
        next_s.key_permit = entry_state && s.key_req && f[ssi_pkg::IN_HW_ENABLE]
                            && f[ssi_pkg::IN_STOPPERS_IN] && f[ssi_pkg::IN_HAZARDS_OFF];
        next_s.door_permit = entry_state && s.door_req && f[ssi_pkg::IN_HW_ENABLE]
                             && f[ssi_pkg::IN_STOPPERS_IN] && f[ssi_pkg::IN_HAZARDS_OFF];

        // apb: answer one cycle after setup, writes land at the completing edge
        next_s.pready = rd_setup;
        next_s.pslverr = rd_setup && !mapped;
        if (rd_setup) begin
            unique case (paddr)
                ssi_pkg::OFS_CTRL: next_s.prdata = {28'h0000000, s.door_req, s.key_req, s.access};
                ssi_pkg::OFS_STATUS: next_s.prdata = {3'h0, f, 6'h00, s.access, 1'h0, timer_active,
                                                     s.violation, s.ilk, s.search_reset, s.preset};
                ssi_pkg::OFS_IRQ_STAT: next_s.prdata = {27'h0000000, s.irq_stat};
                ssi_pkg::OFS_IRQ_MASK: next_s.prdata = {27'h0000000, s.irq_mask};
                default: next_s.prdata = 32'h00000000;
            endcase
        end
        if (wr && paddr == ssi_pkg::OFS_CTRL) begin
            next_s.key_req = pwdata[ssi_pkg::CTRL_KEY_BIT];
            next_s.door_req = pwdata[ssi_pkg::CTRL_DOOR_BIT];
            // closing the zone is refused without a completed search
            if (!(wr_access == ssi_pkg::SSI_RESTRICTED || wr_access == ssi_pkg::SSI_NO_ACCESS)
                || s.search_reset) begin
                next_s.access = ssi_pkg::ssi_access_t'(wr_access);
            end
        end
        if (wr && paddr == ssi_pkg::OFS_IRQ_MASK) begin
            next_s.irq_mask = pwdata[ssi_pkg::IRQ_W-1:0];
        end
        // write-one-to-clear; a same-cycle event wins over the clear
        if (wr && paddr == ssi_pkg::OFS_IRQ_STAT) begin
            next_s.irq_stat = s.irq_stat & ~pwdata[ssi_pkg::IRQ_W-1:0];
        end
        next_s.irq_stat = next_s.irq_stat | events;
        next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.access <= ssi_pkg::ssi_access_t'(ssi_pkg::ACCESS_RESET);
            s.irq_mask <= ssi_pkg::IRQ_MASK_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign stopper_permit = s.stopper_permit;
    assign hazard_permit = s.hazard_permit;
    assign modulator_power_source_permit = s.mod_permit;
    assign key_release_permit = s.key_permit;
    assign door_latch_permit = s.door_permit;
    assign preset_active = s.preset;
    assign search_reset_active = s.search_reset;
    assign irq = s.irq;

    preset_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        f[ssi_pkg::IN_PRESET] && !s.search_reset |=> s.preset)
        else $error("preset command did not set the preset latch");

    preset_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.preset && !f[ssi_pkg::IN_PRESET] && !timer_active && !s.search_reset |=> !s.preset)
        else $error("preset held without hold path");

    sr_set_qual_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s.search_reset) |-> $past(f[ssi_pkg::IN_RESET_LOCAL] && f[ssi_pkg::IN_RESET_ROOM]
            && f[ssi_pkg::IN_GATE_CLOSED] && f[ssi_pkg::IN_DOOR_CLOSED] && f[ssi_pkg::IN_KEYS_COMPLETE]
            && (&s.ilk)))
        else $error("search reset set without all qualifiers");

    sr_self_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.search_reset && quals |=> s.search_reset)
        else $error("search reset dropped with qualifiers true");

    sr_loss_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.search_reset && !quals |=> !s.search_reset)
        else $error("search reset kept after qualifier loss");

    preset_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(s.search_reset) |-> !s.preset)
        else $error("preset survived search reset loss");

    stopper_withdraw_a: assert property (@(posedge ref_clk) disable iff (rst)
        !s.search_reset |-> !s.stopper_permit && !s.hazard_permit)
        else $error("beam permits without search reset");

    entry_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.key_permit || s.door_permit |-> $past(f[ssi_pkg::IN_STOPPERS_IN] && f[ssi_pkg::IN_HAZARDS_OFF]))
        else $error("entry permit without stoppers in and hazards off");

    violation_mod_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s.violation) |-> !s.mod_permit && !s.stopper_permit && !s.hazard_permit)
        else $error("violation did not drop all permits");

    entry_mod_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(s.mod_permit) |-> s.violation)
        else $error("modulator permit dropped without violation");

    // a trip never heals by itself, whatever the contact does afterwards
    trip_latch_a: assert property (@(posedge ref_clk) disable iff (rst)
        !ilk_reset |=> (s.ilk & ~$past(s.ilk)) == 3'h0)
        else $error("interlock latch set without a reset");

    trip_catch_a: assert property (@(posedge ref_clk) disable iff (rst)
        !(&contacts) |=> (s.ilk & $past(~contacts)) == 3'h0)
        else $error("open contact left its latch set");

    raise_guard_a: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(s.access) && (s.access == ssi_pkg::SSI_RESTRICTED || s.access == ssi_pkg::SSI_NO_ACCESS)
        |-> $past(s.search_reset))
        else $error("zone closed without search reset");

    preset_cause_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s.preset) |-> $past(f[ssi_pkg::IN_PRESET]))
        else $error("preset latch set without a preset command");

    hold_reload_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.preset && !f[ssi_pkg::IN_KEYS_COMPLETE] && !f[ssi_pkg::IN_GATE_CLOSED] |=> timer_active)
        else $error("hold timer idle while keys out and gate open");

    sr_preset_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s.search_reset) |-> $past(s.preset))
        else $error("search reset set without a live preset");

    entry_state_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.key_permit || s.door_permit |-> $past(entry_state))
        else $error("entry permit outside an entry state");

    viol_cause_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s.violation) |-> $past(beam_zone && s.search_reset))
        else $error("violation raised outside a beam zone loss");

    sw_enable_a: assert property (@(posedge ref_clk) disable iff (rst)
        !f[ssi_pkg::IN_HW_ENABLE] && !f[ssi_pkg::IN_ILK_RESET]
        |=> !$fell(s.violation) && (s.ilk & ~$past(s.ilk)) == 3'h0)
        else $error("interlock reset acted without the hardware enable");
endmodule

// ---- hdl/ssi_pkg.sv ----
package ssi_pkg;

    // access states, gray ordered from most open to most closed
    typedef enum logic [1:0] {
        SSI_PERMITTED  = 2'h0,
        SSI_CONTROLLED = 2'h1,
        SSI_RESTRICTED = 2'h3,
        SSI_NO_ACCESS  = 2'h2
    } ssi_access_t;

    localparam logic [1:0] ACCESS_RESET = 2'h0;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

    // control register fields
    localparam int CTRL_ACCESS_LSB = 0;
    localparam int CTRL_KEY_BIT = 2;
    localparam int CTRL_DOOR_BIT = 3;
    // command register fields (self clearing)
    localparam int CMD_ILK_RESET_BIT = 0;
    // status register fields
    localparam int STAT_PRESET_BIT = 0;
    localparam int STAT_SR_BIT = 1;
    localparam int STAT_ILK_LSB = 2;
    localparam int STAT_VIOL_BIT = 5;
    localparam int STAT_TIMER_BIT = 6;
    localparam int STAT_ACCESS_LSB = 8;
    localparam int STAT_INPUTS_LSB = 16;

    // interrupt status / mask fields
    localparam int IRQ_W = 5;
    localparam int IRQ_PRESET_SET = 0;
    localparam int IRQ_SR_SET = 1;
    localparam int IRQ_SR_LOST = 2;
    localparam int IRQ_ILK_TRIP = 3;
    localparam int IRQ_VIOLATION = 4;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;

    // filtered input vector positions
    localparam int NUM_IN = 13;
    localparam int IN_PRESET = 0;
    localparam int IN_KEYS_COMPLETE = 1;
    localparam int IN_GATE_CLOSED = 2;
    localparam int IN_DOOR_CLOSED = 3;
    localparam int IN_RESET_LOCAL = 4;
    localparam int IN_RESET_ROOM = 5;
    localparam int IN_DOOR_SW_OK = 6;
    localparam int IN_EOFF_OK = 7;
    localparam int IN_EMERG_OK = 8;
    localparam int IN_STOPPERS_IN = 9;
    localparam int IN_HAZARDS_OFF = 10;
    localparam int IN_HW_ENABLE = 11;
    localparam int IN_ILK_RESET = 12;

    // timing
    localparam longint unsigned CLK_HZ = 100_000_000;
    localparam longint unsigned PRESET_HOLD_S = 120;
    localparam longint unsigned PRESET_HOLD_CYC = PRESET_HOLD_S * CLK_HZ;
    localparam longint unsigned DEBOUNCE_US = 10_000;
    localparam longint unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_HZ / 1_000_000;

endpackage

// ---- verif/search_secure_interlock_bench.sv ----
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end

module search_secure_interlock_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SETTLE = 12;
    localparam logic [32:0] ALL = 33'h1FFFFFFFF;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rnd;
    logic preset_push_command = 1'h0, key_bank_complete = 1'h0, inner_gate_closed = 1'h0;
    logic outer_door_closed = 1'h0, reset_button_local = 1'h0, reset_button_room = 1'h0;
    logic door_switch_ok = 1'h0, emergency_off_ok = 1'h0, emergency_entry_ok = 1'h0;
    logic hw_enable = 1'h0, interlock_reset_button = 1'h0, snap = 1'h0;
    logic slow = 1'h0, stuck_stopper = 1'h0, stuck_hazard = 1'h0, stoppers_inserted, hazards_off;
    logic stopper_permit, hazard_permit, modulator_power_source_permit, key_release_permit;
    logic door_latch_permit, preset_active, search_reset_active, irq;
    logic [32:0] rd_q[$], rd_m[$], re, rm;
    logic [7:0] out_q[$], oe;
    int miscompares = 0;
    int checks_done = 0;

    ssi_interlock #(.PRESET_HOLD_CYCLES(80), .DEBOUNCE_CYCLES(4)) i_ssi_interlock (.*);
    ssi_field i_ssi_field (.*);

    always #5 ref_clk = ~ref_clk;

    // second process: each result is matched against the oldest note
    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'h1 && !pwrite) begin
            re = rd_q.pop_front();
            rm = rd_m.pop_front();
            `CHK({pslverr, prdata} & rm, re)
        end
        if (snap) begin
            oe = out_q.pop_front();
            `CHK({irq, search_reset_active, preset_active, door_latch_permit, key_release_permit,
                  modulator_power_source_permit, hazard_permit, stopper_permit}, oe)
        end
    end

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            stop_test();
        end
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
        rd_q.push_back(e & m);
        rd_m.push_back(m);
        apb(1'h0, a, 32'h0);
    endtask

    task automatic chk_out(input logic [7:0] e);
        out_q.push_back(e);
        @(posedge ref_clk);
        snap <= 1'h1;
        @(posedge ref_clk);
        snap <= 1'h0;
    endtask

    initial begin
        rnd = $urandom(32'h2A68);
        chk_out(8'h00);
        wait_cyc(1);
        rst <= 1'h0;
        wait_cyc(SETTLE);
        chk_out(8'h04);
        rd(ssi_pkg::OFS_CTRL, 33'h0, ALL);
        rd(ssi_pkg::OFS_IRQ_MASK, 33'h0, ALL);
        rd(8'h14, 33'h100000000, ALL);
        rnd = $urandom();
        apb(1'h1, ssi_pkg::OFS_IRQ_MASK, rnd);
        rd(ssi_pkg::OFS_IRQ_MASK, {28'h0, rnd[4:0]}, 33'h1F);
        apb(1'h1, ssi_pkg::OFS_IRQ_MASK, 32'h0);
        door_switch_ok <= 1'h1;
        emergency_off_ok <= 1'h1;
        emergency_entry_ok <= 1'h1;
        hw_enable <= 1'h1;
        interlock_reset_button <= 1'h1;
        wait_cyc(8);
        interlock_reset_button <= 1'h0;
        wait_cyc(SETTLE);
        rd(ssi_pkg::OFS_STATUS, 33'h1C, 33'h1C);
        apb(1'h1, ssi_pkg::OFS_CTRL, 32'h3);
        rd(ssi_pkg::OFS_CTRL, 33'h0, 33'h3);
        for (int pass = 0; pass < 2; pass++) begin
            inner_gate_closed <= 1'h0;
            preset_push_command <= 1'h1;
            wait_cyc(8);
            preset_push_command <= 1'h0;
            wait_cyc(SETTLE);
            chk_out(8'h24);
            wait_cyc(100);
            chk_out(8'h24);
            inner_gate_closed <= 1'h1;
            wait_cyc(SETTLE);
            // first pass waits with the gate closed until the hold timer runs out
            if (pass == 0) begin
                wait_cyc(30);
                chk_out(8'h24);
                wait_cyc(50);
                chk_out(8'h04);
            end
        end
        key_bank_complete <= 1'h1;
        outer_door_closed <= 1'h1;
        reset_button_local <= 1'h1;
        wait_cyc(8);
        reset_button_local <= 1'h0;
        wait_cyc(SETTLE);
        chk_out(8'h24);
        reset_button_local <= 1'h1;
        reset_button_room <= 1'h1;
        wait_cyc(8);
        reset_button_local <= 1'h0;
        reset_button_room <= 1'h0;
        wait_cyc(SETTLE);
        chk_out(8'h64);
        wait_cyc(100);
        chk_out(8'h64);
        apb(1'h1, ssi_pkg::OFS_CTRL, 32'h3);
        rd(ssi_pkg::OFS_CTRL, 33'h3, 33'h3);
        slow <= 1'h1;
        chk_out(8'h67);
        apb(1'h1, ssi_pkg::OFS_IRQ_MASK, 32'h4);
        wait_cyc(50);
        slow <= 1'h0;
        emergency_off_ok <= 1'h0;
        wait_cyc(SETTLE);
        chk_out(8'h80);
        emergency_off_ok <= 1'h1;
        wait_cyc(SETTLE);
        rd(ssi_pkg::OFS_STATUS, 33'h34, 33'h3F);
        rd(ssi_pkg::OFS_IRQ_STAT, 33'h1F, ALL);
        apb(1'h1, ssi_pkg::OFS_IRQ_STAT, 32'h1F);
        rd(ssi_pkg::OFS_IRQ_STAT, 33'h0, ALL);
        chk_out(8'h00);
        hw_enable <= 1'h0;
        wait_cyc(SETTLE);
        apb(1'h1, ssi_pkg::OFS_CMD, 32'h1);
        rd(ssi_pkg::OFS_STATUS, 33'h20, 33'h20);
        hw_enable <= 1'h1;
        wait_cyc(SETTLE);
        apb(1'h1, ssi_pkg::OFS_CMD, 32'h1);
        rd(ssi_pkg::OFS_STATUS, 33'h1C, 33'h3C);
        chk_out(8'h04);
        apb(1'h1, ssi_pkg::OFS_CTRL, 32'hD);
        wait_cyc(3);
        chk_out(8'h1C);
        stuck_hazard <= 1'h1;
        wait_cyc(SETTLE);
        chk_out(8'h04);
        stuck_hazard <= 1'h0;
        stuck_stopper <= 1'h1;
        wait_cyc(SETTLE);
        chk_out(8'h04);
        stuck_stopper <= 1'h0;
        apb(1'h1, ssi_pkg::OFS_CTRL, 32'hC);
        wait_cyc(SETTLE);
        chk_out(8'h1C);
        rst <= 1'h1;
        wait_cyc(1);
        chk_out(8'h00);
        rst <= 1'h0;
        wait_cyc(SETTLE);
        chk_out(8'h04);
        wait_cyc(2);
        if (out_q.size() != 0 || rd_q.size() != 0) begin
            miscompares++;
        end
        stop_test();
    end
endmodule

// ---- verif/ssi_field.sv ----
module ssi_field (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic stopper_permit,
    input wire logic hazard_permit,
    input wire logic slow,
    input wire logic stuck_stopper,
    input wire logic stuck_hazard,
    output logic stoppers_inserted,
    output logic hazards_off
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    logic is_in;
    logic is_off;

    // actuators lag their permits; safe position at power-up
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            is_in <= 1'h1;
            is_off <= 1'h1;
        end else if ({is_in, is_off} != {~stopper_permit, ~hazard_permit}) begin
            cnt <= cnt + 1;
            if (cnt >= (slow ? 20 : 2)) begin
                is_in <= ~stopper_permit;
                is_off <= ~hazard_permit;
                cnt <= 0;
            end
        end else begin
            cnt <= 0;
        end
    end

    // a stuck contact reports the unsafe level, never a kinder one
    assign stoppers_inserted = is_in & ~stuck_stopper;
    assign hazards_off = is_off & ~stuck_hazard;
endmodule
